// *** pat_gap_timer.sv ***
// Purpose: holds off the next frame for the inter-packet gap after a frame ends
// Assumes: frame_end_i is a one-cycle pulse from logic on clk_i
// Notes:   a frame end during a running gap is ignored, the gap is not stretched
`timescale 1ns/1ps
`include "pat_regs.svh"

module pat_gap_timer #(
  parameter logic [7:0] SHORT_CYC = 8'(`PAT_GAP_SHORT_CYC),
  parameter logic [7:0] LONG_CYC  = 8'(`PAT_GAP_LONG_CYC)
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic short_i,
  input  wire logic frame_end_i,
  output logic      gap_active_o
);
  import pat_pkg::*;

  pat_timer_type t_r;
  pat_timer_type t_nxt;

  always_comb
  begin
    t_nxt = t_r;
    unique case (t_r.st)
      PAT_GAP_IDLE:
      begin
        if (frame_end_i)
        begin
          t_nxt.st     = PAT_GAP_HOLD;
          t_nxt.cnt    = short_i ? SHORT_CYC : LONG_CYC;
          t_nxt.active = 1'b1;
        end
      end
      PAT_GAP_HOLD:
      begin
        t_nxt.cnt = t_r.cnt - 8'h01;
        if (t_r.cnt == 8'h01)
        begin
          t_nxt.st     = PAT_GAP_IDLE;
          t_nxt.active = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      t_r <= '{st: PAT_GAP_IDLE, cnt: 8'h00, active: 1'b0};
    else
      t_r <= t_nxt;
  end

  assign gap_active_o = t_r.active;

  // helper: length of each gap and the length it was meant to have
  logic [7:0] run_r;
  logic [7:0] want_r;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      run_r  <= 8'h00;
      want_r <= 8'h00;
    end
    else if (t_r.st == PAT_GAP_IDLE && frame_end_i)
    begin
      run_r  <= 8'h00;
      want_r <= short_i ? SHORT_CYC : LONG_CYC;
    end
    else if (t_r.active)
      run_r <= run_r + 8'h01;
  end

  chk_gap_length: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(t_r.active) |-> run_r == want_r)
    else $error("gap length differs from the selected gap");

endmodule : pat_gap_timer

// *** pat_pkg.sv ***
// Purpose: shared types of the trim bank
// Assumes: pat_regs.svh supplies the numbers
// Notes:   state of each module is one packed struct
package pat_pkg;

  typedef enum logic [2:0] {
    PAT_R_NONE = 3'b000,
    PAT_R_AMP  = 3'b001,
    PAT_R_TERM = 3'b010,
    PAT_R_ANA  = 3'b011,
    PAT_R_RX   = 3'b100,
    PAT_R_GEN  = 3'b101
  } pat_reg_type;

  typedef enum logic {
    PAT_GAP_IDLE = 1'b0,
    PAT_GAP_HOLD = 1'b1
  } pat_gap_type;

  typedef struct packed {
    logic        ack;
    logic [15:0] rdat;
    logic [15:0] amp;
    logic [15:0] term;
    logic [15:0] ana;
    logic [15:0] rx;
    logic [15:0] gen;
    logic [3:0]  term_s_app;
    logic [3:0]  term_x_app;
  } pat_bank_type;

  typedef struct packed {
    pat_gap_type st;
    logic [7:0]  cnt;
    logic        active;
  } pat_timer_type;

endpackage : pat_pkg

// *** pat_regs.svh ***
// Purpose: offsets, field positions, reset values and timing counts of the trim bank
// Assumes: register indices are word indices; byte address is index times four
// Notes:   included by both modules and by the bench
`ifndef PAT_REGS_SVH
`define PAT_REGS_SVH

`define PAT_ADR_W           16
`define PAT_IDX_AMP         16'h030D
`define PAT_IDX_TERM        16'h030E
`define PAT_IDX_ANA         16'h0404
`define PAT_IDX_RX          16'h040D
`define PAT_IDX_GEN         16'h0456

`define PAT_RST_AMP         16'h0410
`define PAT_RST_TERM        16'h0000
`define PAT_RST_ANA         16'h0080
`define PAT_RST_RX          16'h0000
`define PAT_RST_GEN         16'h0008

// writable bits; termination bits 1-0 are read-only zero
`define PAT_WMASK_ALL       16'hFFFF
`define PAT_WMASK_TERM      16'hFFFC

`define PAT_AMP_LSB         0
`define PAT_AMP_W           6
`define PAT_TERM_S_LSB      12
`define PAT_TERM_S_EN       11
`define PAT_TERM_X_LSB      7
`define PAT_TERM_X_EN       6
`define PAT_TERM_W          4
`define PAT_RX_LSB          0
`define PAT_RX_W            5
`define PAT_GEN_SHORT_BIT   3

`define PAT_CLK_NS          10
`define PAT_GAP_SHORT_NS    120
`define PAT_GAP_LONG_NS     200
`define PAT_GAP_SHORT_CYC   ((`PAT_GAP_SHORT_NS + `PAT_CLK_NS - 1) / `PAT_CLK_NS)
`define PAT_GAP_LONG_CYC    ((`PAT_GAP_LONG_NS + `PAT_CLK_NS - 1) / `PAT_CLK_NS)

`endif

// *** pat_trim_bank.sv ***
// Purpose: analog trim and gap option registers behind a classic Wishbone slave
// Assumes: single clock, synchronous active-high reset, 32-bit bus, 16-bit registers
// Notes:   one wait state: ack follows the request by one cycle, writes land on the ack edge
// Behaviour
// - six-bit plus-one amplitude, straight pairs, resets 10h, codes 08h-18h
// - four-bit straight 10M termination value in bits 15-12, resets zero
// - straight termination value applied only while enable bit 11 is one
// - four-bit crossed 10M termination value in bits 10-7, resets zero
// - crossed termination value applied only while enable bit 6 is one
// - five-bit 10M receive comparator level in bits 4-0, resets zero
// - short gap enable bit 3 resets one: 120 ns gap, else 200 ns
`timescale 1ns/1ps
`include "pat_regs.svh"

module pat_trim_bank (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [`PAT_ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  input  wire logic                   frame_end_i,
  output logic                        gap_active_o,
  output logic      [`PAT_AMP_W-1:0]  plus_one_level_straight_o,
  output logic      [`PAT_TERM_W-1:0] term_value_straight_10m_o,
  output logic                        term_override_straight_10m_en_o,
  output logic      [`PAT_TERM_W-1:0] term_value_crossed_10m_o,
  output logic                        term_override_crossed_10m_en_o,
  output logic      [`PAT_RX_W-1:0]   rx_10m_comparator_level_o,
  output logic                        short_gap_enable_o,
  output logic      [15:0]            analog_driver_reserved_o
);
  import pat_pkg::*;

  localparam pat_bank_type RST_BANK = '{
    ack:        1'b0,
    rdat:       16'h0000,
    amp:        `PAT_RST_AMP,
    term:       `PAT_RST_TERM,
    ana:        `PAT_RST_ANA,
    rx:         `PAT_RST_RX,
    gen:        `PAT_RST_GEN,
    term_s_app: 4'h0,
    term_x_app: 4'h0
  };

  pat_bank_type b_r;
  pat_bank_type b_nxt;

  // word-aligned byte address to register; misaligned or unknown is none
  function automatic pat_reg_type decode(input logic [`PAT_ADR_W-1:0] adr);
    pat_reg_type r;
    r = PAT_R_NONE;
    if (adr == 16'(`PAT_IDX_AMP << 2))
      r = PAT_R_AMP;
    else if (adr == 16'(`PAT_IDX_TERM << 2))
      r = PAT_R_TERM;
    else if (adr == 16'(`PAT_IDX_ANA << 2))
      r = PAT_R_ANA;
    else if (adr == 16'(`PAT_IDX_RX << 2))
      r = PAT_R_RX;
    else if (adr == 16'(`PAT_IDX_GEN << 2))
      r = PAT_R_GEN;
    return r;
  endfunction : decode

  // byte-lane merge; only lanes 0 and 1 carry register bits
  function automatic logic [15:0] merge(
    input logic [15:0] old,
    input logic [31:0] wdat,
    input logic [3:0]  sel,
    input logic [15:0] wmask
  );
    logic [15:0] m;
    m = {{8{sel[1]}}, {8{sel[0]}}} & wmask;
    return (old & ~m) | (wdat[15:0] & m);
  endfunction : merge

  // gated termination code: zero whenever the override is off
  function automatic logic [3:0] gate_term(input logic en, input logic [3:0] val);
    return en ? val : 4'h0;
  endfunction : gate_term

  logic        req;
  pat_reg_type sel_reg;

  assign req     = wb_cyc_i & wb_stb_i;
  assign sel_reg = decode(wb_adr_i);

  always_comb
  begin
    b_nxt     = b_r;
    b_nxt.ack = 1'b0;
    // ack drops in the cycle after it was given; a request still held after the ack edge is answered again at the next edge
    if (req && !b_r.ack)
    begin
      b_nxt.ack = 1'b1;
      unique case (sel_reg)
        PAT_R_NONE: b_nxt.rdat = 16'h0000;
        PAT_R_AMP:  b_nxt.rdat = b_r.amp;
        PAT_R_TERM: b_nxt.rdat = b_r.term;
        PAT_R_ANA:  b_nxt.rdat = b_r.ana;
        PAT_R_RX:   b_nxt.rdat = b_r.rx;
        PAT_R_GEN:  b_nxt.rdat = b_r.gen;
        default:    b_nxt.rdat = 16'h0000;
      endcase
    end
    // the write lands on the edge where the master sees ack
    if (req && b_r.ack && wb_we_i)
    begin
      unique case (sel_reg)
        PAT_R_NONE: b_nxt.amp = b_r.amp;
        PAT_R_AMP:  b_nxt.amp = merge(b_r.amp, wb_dat_i, wb_sel_i, `PAT_WMASK_ALL);
        PAT_R_TERM: b_nxt.term = merge(b_r.term, wb_dat_i, wb_sel_i, `PAT_WMASK_TERM);
        PAT_R_ANA:  b_nxt.ana = merge(b_r.ana, wb_dat_i, wb_sel_i, `PAT_WMASK_ALL);
        PAT_R_RX:   b_nxt.rx = merge(b_r.rx, wb_dat_i, wb_sel_i, `PAT_WMASK_ALL);
        PAT_R_GEN:  b_nxt.gen = merge(b_r.gen, wb_dat_i, wb_sel_i, `PAT_WMASK_ALL);
        default:    b_nxt.amp = b_r.amp;
      endcase
    end
    // applied codes follow the new register value on the same edge
    b_nxt.term_s_app = gate_term(b_nxt.term[`PAT_TERM_S_EN],
                                 b_nxt.term[`PAT_TERM_S_LSB +: `PAT_TERM_W]);
    b_nxt.term_x_app = gate_term(b_nxt.term[`PAT_TERM_X_EN],
                                 b_nxt.term[`PAT_TERM_X_LSB +: `PAT_TERM_W]);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      b_r <= RST_BANK;
    else
      b_r <= b_nxt;
  end

  assign wb_dat_o                        = {16'h0000, b_r.rdat};
  assign wb_ack_o                        = b_r.ack;
  assign plus_one_level_straight_o       = b_r.amp[`PAT_AMP_LSB +: `PAT_AMP_W];
  assign term_value_straight_10m_o       = b_r.term_s_app;
  assign term_override_straight_10m_en_o = b_r.term[`PAT_TERM_S_EN];
  assign term_value_crossed_10m_o        = b_r.term_x_app;
  assign term_override_crossed_10m_en_o  = b_r.term[`PAT_TERM_X_EN];
  assign rx_10m_comparator_level_o       = b_r.rx[`PAT_RX_LSB +: `PAT_RX_W];
  assign short_gap_enable_o              = b_r.gen[`PAT_GEN_SHORT_BIT];
  assign analog_driver_reserved_o        = b_r.ana;

  // the gap length is picked from the live option bit at each frame end that starts a gap
  pat_gap_timer u_gap (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .short_i      (b_r.gen[`PAT_GEN_SHORT_BIT]),
    .frame_end_i  (frame_end_i),
    .gap_active_o (gap_active_o)
  );

  sequence s_wr_done(pat_reg_type r);
    req && wb_we_i && b_r.ack && sel_reg == r;
  endsequence

  sequence s_rd_ask;
    req && !b_r.ack && !wb_we_i;
  endsequence

  chk_amp_reset: assert property (@(posedge clk_i)
    $fell(rst_i) |-> plus_one_level_straight_o == 6'h10 && short_gap_enable_o)
    else $error("trim bank did not come out of reset at its defaults");

  chk_amp_write: assert property (@(posedge clk_i) disable iff (rst_i)
    s_wr_done(PAT_R_AMP) ##0 wb_sel_i[0] |=>
      plus_one_level_straight_o == $past(wb_dat_i[5:0]))
    else $error("amplitude write did not reach the output");

  chk_term_s_write: assert property (@(posedge clk_i) disable iff (rst_i)
    s_wr_done(PAT_R_TERM) ##0 wb_sel_i[1] |=>
      b_r.term[15:12] == $past(wb_dat_i[15:12]))
    else $error("straight termination field not stored");

  chk_term_s_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    term_value_straight_10m_o == (term_override_straight_10m_en_o ? b_r.term[15:12] : 4'h0))
    else $error("straight termination applied while its override is off");

  chk_term_x_write: assert property (@(posedge clk_i) disable iff (rst_i)
    s_wr_done(PAT_R_TERM) ##0 (wb_sel_i[1] && wb_sel_i[0]) |=>
      b_r.term[10:7] == $past(wb_dat_i[10:7]))
    else $error("crossed termination field not stored");

  chk_term_x_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    !term_override_crossed_10m_en_o |-> term_value_crossed_10m_o == 4'h0)
    else $error("crossed termination applied while its override is off");

  chk_rx_read: assert property (@(posedge clk_i) disable iff (rst_i)
    s_rd_ask ##0 sel_reg == PAT_R_RX |=>
      wb_ack_o && wb_dat_o[4:0] == rx_10m_comparator_level_o)
    else $error("comparator level read back wrong");

  chk_gap_write: assert property (@(posedge clk_i) disable iff (rst_i)
    s_wr_done(PAT_R_GEN) ##0 wb_sel_i[0] |=> short_gap_enable_o == $past(wb_dat_i[3]))
    else $error("gap option write lost");

  chk_ro_bits: assert property (@(posedge clk_i) disable iff (rst_i)
    b_r.term[1:0] == 2'b00)
    else $error("read-only termination bits changed");

  chk_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  // bus protocol: one wait state, writes only on the ack edge
  sequence s_any_ask;
    req && !b_r.ack;
  endsequence

  sequence s_rd_of(pat_reg_type r);
    req && !b_r.ack && !wb_we_i && sel_reg == r;
  endsequence

  chk_ack_next: assert property (@(posedge clk_i) disable iff (rst_i)
    s_any_ask |=> wb_ack_o)
    else $error("request not answered after one cycle");

  chk_ack_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !req |=> !wb_ack_o)
    else $error("ack given without a request");

  chk_dat_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(req && !b_r.ack) |=> $stable(wb_dat_o))
    else $error("read data moved between answers");

  chk_no_early_wr: assert property (@(posedge clk_i) disable iff (rst_i)
    s_any_ask ##0 wb_we_i |=>
      $stable({b_r.amp, b_r.term, b_r.ana, b_r.rx, b_r.gen}))
    else $error("write landed before ack");

  chk_wr_none_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    s_wr_done(PAT_R_NONE) |=>
      $stable({b_r.amp, b_r.term, b_r.ana, b_r.rx, b_r.gen}))
    else $error("unmapped write changed a register");

  chk_rd_none: assert property (@(posedge clk_i) disable iff (rst_i)
    s_rd_of(PAT_R_NONE) |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read returned data");

  chk_rd_amp: assert property (@(posedge clk_i) disable iff (rst_i)
    s_rd_of(PAT_R_AMP) |=>
      wb_dat_o[15:0] == $past(b_r.amp))
    else $error("amplitude register read back wrong");

  chk_rd_term: assert property (@(posedge clk_i) disable iff (rst_i)
    s_rd_of(PAT_R_TERM) |=>
      wb_dat_o[15:0] == $past(b_r.term))
    else $error("termination register read back wrong");

  chk_rd_ana: assert property (@(posedge clk_i) disable iff (rst_i)
    s_rd_of(PAT_R_ANA) |=>
      wb_dat_o[15:0] == $past(b_r.ana))
    else $error("reserved analog register read back wrong");

  chk_rd_gen: assert property (@(posedge clk_i) disable iff (rst_i)
    s_rd_of(PAT_R_GEN) |=>
      wb_dat_o[15:0] == $past(b_r.gen))
    else $error("general register read back wrong");

  chk_rx_write: assert property (@(posedge clk_i) disable iff (rst_i)
    s_wr_done(PAT_R_RX) ##0 wb_sel_i[0] |=>
      rx_10m_comparator_level_o == $past(wb_dat_i[4:0]))
    else $error("comparator level write lost");

  chk_ana_write: assert property (@(posedge clk_i) disable iff (rst_i)
    s_wr_done(PAT_R_ANA) ##0 (wb_sel_i[1] && wb_sel_i[0]) |=>
      analog_driver_reserved_o == $past(wb_dat_i[15:0]))
    else $error("reserved analog write lost");

  // lanes with sel low keep their bytes
  chk_amp_keep_hi: assert property (@(posedge clk_i) disable iff (rst_i)
    s_wr_done(PAT_R_AMP) ##0 !wb_sel_i[1] |=>
      b_r.amp[15:8] == $past(b_r.amp[15:8]))
    else $error("amplitude high byte changed with its lane off");

  chk_amp_keep_lo: assert property (@(posedge clk_i) disable iff (rst_i)
    s_wr_done(PAT_R_AMP) ##0 !wb_sel_i[0] |=>
      $stable(plus_one_level_straight_o))
    else $error("amplitude changed with its lane off");

  chk_term_x_on: assert property (@(posedge clk_i) disable iff (rst_i)
    term_override_crossed_10m_en_o |-> term_value_crossed_10m_o == b_r.term[10:7])
    else $error("crossed termination not applied while its override is on");

  // defaults seen at the first edge after reset is released
  chk_term_reset: assert property (@(posedge clk_i)
    $fell(rst_i) |-> term_value_straight_10m_o == 4'h0 && !term_override_straight_10m_en_o &&
      term_value_crossed_10m_o == 4'h0 && !term_override_crossed_10m_en_o)
    else $error("termination outputs not at their defaults after reset");

  chk_rx_reset: assert property (@(posedge clk_i)
    $fell(rst_i) |-> rx_10m_comparator_level_o == 5'h00)
    else $error("comparator level not at its default after reset");

  chk_ana_reset: assert property (@(posedge clk_i)
    $fell(rst_i) |-> analog_driver_reserved_o == `PAT_RST_ANA)
    else $error("reserved analog register not at its default after reset");

  chk_gap_reset: assert property (@(posedge clk_i)
    $fell(rst_i) |-> !gap_active_o)
    else $error("gap running right after reset");

endmodule : pat_trim_bank

// *** test_pat_trim_bank.sv ***
// Purpose: register, output and gap checks of the trim bank
// Assumes: one wait state bus, registers in the low half of the word
// Notes:   expectations come from the rules, never from read-back
`timescale 1ns/1ps
`include "pat_regs.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end

module test_pat_trim_bank;
  import pat_pkg::*;
  localparam logic [15:0] A_AMP  = 16'(`PAT_IDX_AMP * 4);
  localparam logic [15:0] A_TERM = 16'(`PAT_IDX_TERM * 4);
  localparam logic [15:0] A_ANA  = 16'(`PAT_IDX_ANA * 4);
  localparam logic [15:0] A_RX   = 16'(`PAT_IDX_RX * 4);
  localparam logic [15:0] A_GEN  = 16'(`PAT_IDX_GEN * 4);
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic        fe    = 1'b0;
  logic [15:0] adr   = 16'h0000;
  logic [3:0]  sel   = 4'h0;
  logic [31:0] dat   = 32'h0000_0000;
  logic [31:0] rdat;
  logic        ack, gap, s_en, x_en, short_en;
  logic [5:0]  amp_o;
  logic [3:0]  s_val, x_val;
  logic [4:0]  rx_o;
  logic [15:0] ana_o, q;
  int          err_total   = 0;
  int          checks_done = 0;
  int          cycles      = 0;
  int          len;

  pat_trim_bank i_dut (
    .clk_i                           (clk_i),
    .rst_i                           (rst_i),
    .wb_cyc_i                        (cyc),
    .wb_stb_i                        (stb),
    .wb_we_i                         (we),
    .wb_adr_i                        (adr),
    .wb_sel_i                        (sel),
    .wb_dat_i                        (dat),
    .wb_dat_o                        (rdat),
    .wb_ack_o                        (ack),
    .frame_end_i                     (fe),
    .gap_active_o                    (gap),
    .plus_one_level_straight_o       (amp_o),
    .term_value_straight_10m_o       (s_val),
    .term_override_straight_10m_en_o (s_en),
    .term_value_crossed_10m_o        (x_val),
    .term_override_crossed_10m_en_o  (x_en),
    .rx_10m_comparator_level_o       (rx_o),
    .short_gap_enable_o              (short_en),
    .analog_driver_reserved_o        (ana_o)
  );

  initial
  begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic conclude;
    if (err_total == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  // hold the request until ack is sampled high, then release for a gap cycle
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
                     input logic [3:0] s, output logic [15:0] r);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= s;
    dat <= {16'hA5A5, d};
    @(posedge clk_i);
    while (ack !== 1'b1)
    begin
      @(posedge clk_i);
    end
    r = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    // a write lands on the ack edge; let its outputs settle before the caller looks
    @(negedge clk_i);
  endtask : acc

  task automatic term_case(input logic [15:0] w);
    logic [15:0] e;
    e = w & 16'hFFFC;
    acc(1'b1, A_TERM, w, 4'h3, q);
    acc(1'b0, A_TERM, 16'h0000, 4'h3, q);
    `CHK("term reg", e, q)
    `CHK("term s val", e[11] ? e[15:12] : 4'h0, s_val)
    `CHK("term s en", e[11], s_en)
    `CHK("term x val", e[6] ? e[10:7] : 4'h0, x_val)
    `CHK("term x en", e[6], x_en)
  endtask : term_case

  // a second frame end inside the gap must not stretch it
  task automatic gap_len(output int n);
    @(posedge clk_i);
    fe <= 1'b1;
    @(posedge clk_i);
    fe <= 1'b0;
    n = 0;
    @(posedge clk_i);
    while (gap === 1'b1)
    begin
      n++;
      fe <= (n == 4);
      @(posedge clk_i);
    end
    fe <= 1'b0;
  endtask : gap_len

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      conclude();
    end
  end

  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK("amp out", 6'h10, amp_o)
    `CHK("term out", 10'h000, {s_val, s_en, x_val, x_en})
    `CHK("rx out", 5'h00, rx_o)
    `CHK("short out", 1'b1, short_en)
    `CHK("ana out", 16'h0080, ana_o)
    acc(1'b0, A_AMP, 16'h0000, 4'h3, q);
    `CHK("amp rst", 16'h0410, q)
    acc(1'b0, A_TERM, 16'h0000, 4'h3, q);
    `CHK("term rst", 16'h0000, q)
    acc(1'b0, A_ANA, 16'h0000, 4'h3, q);
    `CHK("ana rst", 16'h0080, q)
    acc(1'b0, A_RX, 16'h0000, 4'h3, q);
    `CHK("rx rst", 16'h0000, q)
    acc(1'b0, A_GEN, 16'h0000, 4'h3, q);
    `CHK("gen rst", 16'h0008, q)
    acc(1'b1, 16'h0000, 16'hFFFF, 4'h3, q);
    acc(1'b0, 16'h0000, 16'h0000, 4'h3, q);
    `CHK("unmapped", 16'h0000, q)
    term_case(16'hFFFF);
    term_case(16'hA280);
    term_case(16'hAAC0);
    term_case(16'h0840);
    // byte lanes: low byte first, then the high byte alone
    acc(1'b1, A_AMP, 16'h3308, 4'h1, q);
    `CHK("amp low", 6'h08, amp_o)
    acc(1'b1, A_AMP, 16'h3318, 4'h2, q);
    acc(1'b0, A_AMP, 16'h0000, 4'h3, q);
    `CHK("amp reg", 16'h3308, q)
    acc(1'b1, A_AMP, 16'h0018, 4'h3, q);
    `CHK("amp top", 6'h18, amp_o)
    acc(1'b1, A_RX, 16'hFFFF, 4'h3, q);
    acc(1'b0, A_RX, 16'h0000, 4'h3, q);
    `CHK("rx reg", 16'hFFFF, q)
    `CHK("rx out", 5'h1F, rx_o)
    acc(1'b1, A_ANA, 16'h1234, 4'h3, q);
    `CHK("ana out", 16'h1234, ana_o)
    gap_len(len);
    `CHK("gap short", 12, len)
    acc(1'b0, A_GEN, 16'h0000, 4'h3, q);
    acc(1'b1, A_GEN, q & ~16'h0008, 4'h3, q);
    `CHK("short out", 1'b0, short_en)
    gap_len(len);
    `CHK("gap long", 20, len)
    // a reset in mid-run brings every trim back to its default
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    `CHK("amp again", 6'h10, amp_o)
    `CHK("rx again", 5'h00, rx_o)
    `CHK("short again", 1'b1, short_en)
    conclude();
  end
endmodule : test_pat_trim_bank
